// ### rtl/dscid_consts.vh
`ifndef DSCID_CONSTS_VH
`define DSCID_CONSTS_VH
// Word layout
`define DSCID_WORD_W 24
`define DSCID_OPC_HI 23
`define DSCID_OPC_LO 16
`define DSCID_W2_ZERO 8'h00
// Control opcodes
`define DSCID_OP_NOP 8'h00
`define DSCID_OP_BRA_COMP 8'h01
`define DSCID_OP_CALL 8'h02
`define DSCID_OP_CALL_IND 8'h03
`define DSCID_OP_GOTO 8'h04
`define DSCID_OP_GOTO_IND 8'h05
`define DSCID_OP_RETURN 8'h06
`define DSCID_OP_RETINT 8'h07
`define DSCID_OP_DO 8'h08
`define DSCID_OP_BCOND_LO 8'h30
`define DSCID_OP_BCOND_HI 8'h35
`define DSCID_OP_BRA 8'h37
`define DSCID_OP_TBLRD 8'h3A
`define DSCID_OP_TBLWR 8'h3B
`define DSCID_OP_SKIP 8'h3C
`define DSCID_OP_MOVD 8'h3E
// Operand classes
`define DSCID_CLS_NOP 3'h0
`define DSCID_CLS_CTRL 3'h1
`define DSCID_CLS_WREG3 3'h2
`define DSCID_CLS_FILE 3'h3
`define DSCID_CLS_LIT 3'h4
`define DSCID_CLS_BIT 3'h5
`define DSCID_CLS_MAC 3'h6
`define DSCID_CLS_DSP 3'h7
// Operand sizes
`define DSCID_SIZE_WORD 2'h0
`define DSCID_SIZE_BYTE 2'h1
`define DSCID_SIZE_DBL 2'h2
// Cycle counts
`define DSCID_CYC_1 2'h1
`define DSCID_CYC_2 2'h2
`define DSCID_CYC_3 2'h3
// Operand limits and fixed registers
`define DSCID_TEN_BIT_UNSIGNED_LITERAL_BYTE_MAX 10'h0FF
`define DSCID_MUL_BASE 4'h4
`define DSCID_AWB_REG 4'hD
`define DSCID_AWB_STEP 4'h2
// Flag positions
`define DSCID_F_C 0
`define DSCID_F_DC 1
`define DSCID_F_N 2
`define DSCID_F_OV 3
`define DSCID_F_Z 4
`define DSCID_D_OA 0
`define DSCID_D_OB 1
`define DSCID_D_SA 2
`define DSCID_D_SB 3
`endif

// ### rtl/dscid_decoder.v
`timescale 1ns/10ps
`include "dscid_consts.vh"

module dscid_decoder (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // Program memory fetch
  input wire FETCH_VALID,
  input wire [23:0] FETCH_WORD,
  output wire FETCH_READY,
  // Execution condition results, valid with the word
  input wire COND_TRUE,
  input wire SKIP_TAKEN,
  // Decoded instruction
  output reg DEC_VALID,
  output reg DEC_NOP,
  output reg NOP_SLOT,
  output reg [7:0] DEC_OPCODE,
  output reg [2:0] DEC_CLASS,
  output reg [1:0] DEC_CYCLES,
  output reg [1:0] DEC_SIZE,
  output reg DEC_SHADOW,
  // Register and file operands
  output reg [12:0] FILE_ADDR,
  output reg DEST_IS_DEFAULT_WORKING_REG,
  output reg [3:0] BASE_SOURCE_REG,
  output reg [3:0] SECOND_SOURCE_REG,
  output reg [1:0] SECOND_SOURCE_MODE,
  output reg [3:0] RESULT_DEST_REG,
  output reg [1:0] RESULT_DEST_MODE,
  output reg [3:0] BIT_SELECT_FIELD,
  // Literals
  output reg [9:0] TEN_BIT_UNSIGNED_LITERAL,
  output reg LIT_RANGE_ERR,
  output reg [15:0] TEN_BIT_SIGNED_LITERAL,
  output reg [15:0] SIXTEEN_BIT_SIGNED_LITERAL,
  output reg [22:0] PROGRAM_ADDRESS_LITERAL,
  output reg PROG_ADDR_ERR,
  output reg WORD2_ERR,
  // DSP operands
  output reg ACC_SEL,
  output reg [3:0] MUL_REG_A,
  output reg [3:0] MUL_REG_B,
  output reg MUL_PAIR_ERR,
  output reg [2:0] X_PREFETCH,
  output reg [2:0] Y_PREFETCH,
  output reg [3:0] X_PREFETCH_DEST,
  output reg [3:0] Y_PREFETCH_DEST,
  output reg [3:0] ACC_WRITEBACK_TARGET,
  output reg ACC_WRITEBACK_POSTINC,
  output reg [3:0] ACC_WRITEBACK_STEP,
  output reg SHIFT_FROM_REG,
  output reg [5:0] SHIFT_LIT,
  // Flag updates from the datapath
  input wire [4:0] EXE_FLAG_WE,
  input wire [4:0] EXE_FLAG_VAL,
  input wire EXE_Z_STICKY,
  input wire [3:0] EXE_DSP_WE,
  input wire [3:0] EXE_DSP_VAL,
  // Status flags
  output wire CARRY_FLAG,
  output wire DIGIT_CARRY_FLAG,
  output wire NEGATIVE_FLAG,
  output wire OVERFLOW_FLAG,
  output wire ZERO_FLAG,
  output wire ACC_A_OVERFLOW_FLAG,
  output wire ACC_B_OVERFLOW_FLAG,
  output wire ACC_A_SATURATE_FLAG,
  output wire ACC_B_SATURATE_FLAG
);

  localparam S_DEC = 3'h0;
  localparam S_W2 = 3'h1;
  localparam S_BUSY = 3'h2;
  localparam S_SKIP1 = 3'h3;
  localparam S_SKIP2 = 3'h4;

  function [2:0] cls_of;
    input [7:0] op;
    begin
      if (op == `DSCID_OP_NOP)
        cls_of = `DSCID_CLS_NOP;
      else if (op[7:6] == 2'b00)
        cls_of = `DSCID_CLS_CTRL;
      else
        cls_of = (op[6:4] >= `DSCID_CLS_FILE) ? op[6:4] : `DSCID_CLS_WREG3;
    end
  endfunction

  function two_word;
    input [7:0] op;
    begin
      two_word = (op == `DSCID_OP_CALL) || (op == `DSCID_OP_GOTO) || (op == `DSCID_OP_DO);
    end
  endfunction

  function [1:0] cycles_of;
    input [7:0] op;
    input cond;
    begin
      if (two_word(op) || op == `DSCID_OP_MOVD)
        cycles_of = `DSCID_CYC_2;
      else if (op == `DSCID_OP_RETURN || op == `DSCID_OP_RETINT)
        cycles_of = `DSCID_CYC_3;
      else if (op == `DSCID_OP_BRA || op == `DSCID_OP_BRA_COMP || op == `DSCID_OP_CALL_IND ||
               op == `DSCID_OP_GOTO_IND || op == `DSCID_OP_TBLRD || op == `DSCID_OP_TBLWR)
        cycles_of = `DSCID_CYC_2;
      else if (((op >= `DSCID_OP_BCOND_LO && op <= `DSCID_OP_BCOND_HI) || op == `DSCID_OP_SKIP) && cond)
        cycles_of = `DSCID_CYC_2;
      else
        cycles_of = `DSCID_CYC_1;
    end
  endfunction

  reg [2:0] state;
  reg [1:0] busy;
  reg [23:0] first_word;
  reg [4:0] mcu_flags;
  reg [3:0] dsp_flags;

  wire take = FETCH_VALID && FETCH_READY;
  wire [7:0] in_op = FETCH_WORD[`DSCID_OPC_HI:`DSCID_OPC_LO];
  // During the second word the fields still come from the first
  wire [23:0] dw = (state == S_W2) ? first_word : FETCH_WORD;
  wire [7:0] op = dw[`DSCID_OPC_HI:`DSCID_OPC_LO];
  wire [2:0] cls = cls_of(op);
  wire cond = (op == `DSCID_OP_SKIP) ? SKIP_TAKEN : COND_TRUE;
  wire [1:0] next_cycles = cycles_of(op, cond);
  wire single_emit = (state == S_DEC) && !two_word(in_op);
  wire real_emit = take && (single_emit || state == S_W2);
  wire skip_emit = take && (state == S_SKIP1 || state == S_SKIP2);
  wire [1:0] next_size = (dw[17:16] == 2'h3) ? `DSCID_SIZE_WORD : dw[17:16];
  wire [1:0] mul_a = dw[14:13];
  wire [1:0] mul_b = dw[12:11];

  // Fetch stalls only while extra cycles of an instruction run as NOPs
  assign FETCH_READY = (state != S_BUSY);

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_DEC;
      busy <= 2'h0;
      first_word <= 24'h000000;
      NOP_SLOT <= 1'b0;
    end else begin
      NOP_SLOT <= 1'b0;
      case (state)
        S_DEC: begin
          if (take && two_word(in_op)) begin
            first_word <= FETCH_WORD;
            state <= S_W2;
          end else if (take && op == `DSCID_OP_SKIP && SKIP_TAKEN) begin
            state <= S_SKIP1;
          end else if (take && next_cycles != `DSCID_CYC_1) begin
            busy <= next_cycles - `DSCID_CYC_1;
            state <= S_BUSY;
          end
        end
        S_W2: begin
          if (take) begin
            state <= S_DEC;
          end
        end
        S_BUSY: begin
          NOP_SLOT <= 1'b1;
          busy <= busy - 2'h1;
          if (busy == 2'h1) begin
            state <= S_DEC;
          end
        end
        S_SKIP1: begin
          if (take) begin
            state <= two_word(in_op) ? S_SKIP2 : S_DEC;
          end
        end
        S_SKIP2: begin
          if (take) begin
            state <= S_DEC;
          end
        end
        default: begin
          state <= S_DEC;
        end
      endcase
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      DEC_VALID <= 1'b0;
      DEC_NOP <= 1'b0;
      DEC_OPCODE <= 8'h00;
      DEC_CLASS <= `DSCID_CLS_NOP;
      DEC_CYCLES <= `DSCID_CYC_1;
      DEC_SIZE <= `DSCID_SIZE_WORD;
      DEC_SHADOW <= 1'b0;
      FILE_ADDR <= 13'h0000;
      DEST_IS_DEFAULT_WORKING_REG <= 1'b0;
      BASE_SOURCE_REG <= 4'h0;
      SECOND_SOURCE_REG <= 4'h0;
      SECOND_SOURCE_MODE <= 2'h0;
      RESULT_DEST_REG <= 4'h0;
      RESULT_DEST_MODE <= 2'h0;
      BIT_SELECT_FIELD <= 4'h0;
      TEN_BIT_UNSIGNED_LITERAL <= 10'h000;
      LIT_RANGE_ERR <= 1'b0;
      TEN_BIT_SIGNED_LITERAL <= 16'h0000;
      SIXTEEN_BIT_SIGNED_LITERAL <= 16'h0000;
      PROGRAM_ADDRESS_LITERAL <= 23'h000000;
      PROG_ADDR_ERR <= 1'b0;
      WORD2_ERR <= 1'b0;
      ACC_SEL <= 1'b0;
      MUL_REG_A <= `DSCID_MUL_BASE;
      MUL_REG_B <= `DSCID_MUL_BASE;
      MUL_PAIR_ERR <= 1'b0;
      X_PREFETCH <= 3'h0;
      Y_PREFETCH <= 3'h0;
      X_PREFETCH_DEST <= `DSCID_MUL_BASE;
      Y_PREFETCH_DEST <= `DSCID_MUL_BASE;
      ACC_WRITEBACK_TARGET <= `DSCID_AWB_REG;
      ACC_WRITEBACK_POSTINC <= 1'b0;
      ACC_WRITEBACK_STEP <= 4'h0;
      SHIFT_FROM_REG <= 1'b0;
      SHIFT_LIT <= 6'h00;
    end else begin
      DEC_VALID <= real_emit || skip_emit;
      if (skip_emit) begin
        DEC_NOP <= 1'b1;
        DEC_OPCODE <= `DSCID_OP_NOP;
        DEC_CLASS <= `DSCID_CLS_NOP;
        DEC_CYCLES <= `DSCID_CYC_1;
      end else if (real_emit) begin
        DEC_NOP <= (cls == `DSCID_CLS_NOP);
        DEC_OPCODE <= op;
        DEC_CLASS <= cls;
        DEC_CYCLES <= next_cycles;
        DEC_SIZE <= next_size;
        DEC_SHADOW <= dw[18];
        FILE_ADDR <= dw[12:0];
        DEST_IS_DEFAULT_WORKING_REG <= dw[13];
        BASE_SOURCE_REG <= dw[15:12];
        SECOND_SOURCE_MODE <= dw[11:10];
        SECOND_SOURCE_REG <= dw[9:6];
        RESULT_DEST_MODE <= dw[5:4];
        RESULT_DEST_REG <= dw[3:0];
        BIT_SELECT_FIELD <= dw[15:12];
        TEN_BIT_UNSIGNED_LITERAL <= dw[13:4];
        LIT_RANGE_ERR <= (cls == `DSCID_CLS_LIT) && (next_size == `DSCID_SIZE_BYTE) &&
                         (dw[13:4] > `DSCID_TEN_BIT_UNSIGNED_LITERAL_BYTE_MAX);
        TEN_BIT_SIGNED_LITERAL <= {{6{dw[13]}}, dw[13:4]};
        SIXTEEN_BIT_SIGNED_LITERAL <= dw[15:0];
        PROGRAM_ADDRESS_LITERAL <= {FETCH_WORD[6:0], first_word[15:0]};
        PROG_ADDR_ERR <= (state == S_W2) && first_word[0];
        WORD2_ERR <= (state == S_W2) && (in_op != `DSCID_W2_ZERO);
        ACC_SEL <= dw[15];
        MUL_REG_A <= `DSCID_MUL_BASE + {2'b00, mul_a};
        MUL_REG_B <= `DSCID_MUL_BASE + {2'b00, mul_b};
        // Pairs are kept in ascending order so each distinct pair has one code
        MUL_PAIR_ERR <= (cls == `DSCID_CLS_MAC) && (op[0] ? (mul_a != mul_b) : (mul_a >= mul_b));
        X_PREFETCH <= dw[10:8];
        Y_PREFETCH <= dw[7:5];
        X_PREFETCH_DEST <= `DSCID_MUL_BASE + {2'b00, dw[4:3]};
        Y_PREFETCH_DEST <= `DSCID_MUL_BASE + {2'b00, dw[2:1]};
        ACC_WRITEBACK_TARGET <= `DSCID_AWB_REG;
        ACC_WRITEBACK_POSTINC <= dw[0];
        ACC_WRITEBACK_STEP <= dw[0] ? `DSCID_AWB_STEP : 4'h0;
        SHIFT_FROM_REG <= dw[14];
        SHIFT_LIT <= dw[13:8];
      end
    end
  end

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mcu_flags <= 5'h00;
    end else begin
      if (EXE_FLAG_WE[`DSCID_F_C])
        mcu_flags[`DSCID_F_C] <= EXE_FLAG_VAL[`DSCID_F_C];
      if (EXE_FLAG_WE[`DSCID_F_DC])
        mcu_flags[`DSCID_F_DC] <= EXE_FLAG_VAL[`DSCID_F_DC];
      if (EXE_FLAG_WE[`DSCID_F_N])
        mcu_flags[`DSCID_F_N] <= EXE_FLAG_VAL[`DSCID_F_N];
      if (EXE_FLAG_WE[`DSCID_F_OV])
        mcu_flags[`DSCID_F_OV] <= EXE_FLAG_VAL[`DSCID_F_OV];
      // Sticky update can only clear zero, so multi-word results chain correctly
      if (EXE_FLAG_WE[`DSCID_F_Z])
        mcu_flags[`DSCID_F_Z] <= EXE_Z_STICKY ? (mcu_flags[`DSCID_F_Z] & EXE_FLAG_VAL[`DSCID_F_Z]) :
                                 EXE_FLAG_VAL[`DSCID_F_Z];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : dsp_flag
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
          dsp_flags[g] <= 1'b0;
        else if (EXE_DSP_WE[g])
          dsp_flags[g] <= EXE_DSP_VAL[g];
      end
    end
  endgenerate

  assign CARRY_FLAG = mcu_flags[`DSCID_F_C];
  assign DIGIT_CARRY_FLAG = mcu_flags[`DSCID_F_DC];
  assign NEGATIVE_FLAG = mcu_flags[`DSCID_F_N];
  assign OVERFLOW_FLAG = mcu_flags[`DSCID_F_OV];
  assign ZERO_FLAG = mcu_flags[`DSCID_F_Z];
  assign ACC_A_OVERFLOW_FLAG = dsp_flags[`DSCID_D_OA];
  assign ACC_B_OVERFLOW_FLAG = dsp_flags[`DSCID_D_OB];
  assign ACC_A_SATURATE_FLAG = dsp_flags[`DSCID_D_SA];
  assign ACC_B_SATURATE_FLAG = dsp_flags[`DSCID_D_SB];

endmodule

// ### test/dscid_decoder_tb.sv
`timescale 1ns/10ps
`include "dscid_consts.vh"
module dscid_decoder_tb;
  logic CLK_SYS, RST_N, FETCH_VALID, FETCH_READY, COND_TRUE, SKIP_TAKEN, DEC_VALID, DEC_NOP, NOP_SLOT;
  logic DEC_SHADOW, DEST_IS_DEFAULT_WORKING_REG, LIT_RANGE_ERR, PROG_ADDR_ERR, WORD2_ERR, ACC_SEL;
  logic MUL_PAIR_ERR, ACC_WRITEBACK_POSTINC, SHIFT_FROM_REG, EXE_Z_STICKY, CARRY_FLAG, DIGIT_CARRY_FLAG;
  logic NEGATIVE_FLAG, OVERFLOW_FLAG, ZERO_FLAG, ACC_A_OVERFLOW_FLAG, ACC_B_OVERFLOW_FLAG;
  logic ACC_A_SATURATE_FLAG, ACC_B_SATURATE_FLAG, gap;
  logic [1:0] DEC_CYCLES, DEC_SIZE, SECOND_SOURCE_MODE, RESULT_DEST_MODE;
  logic [2:0] DEC_CLASS, X_PREFETCH, Y_PREFETCH;
  logic [3:0] BASE_SOURCE_REG, SECOND_SOURCE_REG, RESULT_DEST_REG, BIT_SELECT_FIELD, MUL_REG_A, MUL_REG_B;
  logic [3:0] X_PREFETCH_DEST, Y_PREFETCH_DEST, ACC_WRITEBACK_TARGET, ACC_WRITEBACK_STEP, EXE_DSP_WE, EXE_DSP_VAL;
  logic [4:0] EXE_FLAG_WE, EXE_FLAG_VAL;
  logic [5:0] SHIFT_LIT;
  logic [7:0] DEC_OPCODE;
  logic [9:0] TEN_BIT_UNSIGNED_LITERAL;
  logic [12:0] FILE_ADDR;
  logic [15:0] TEN_BIT_SIGNED_LITERAL, SIXTEEN_BIT_SIGNED_LITERAL;
  logic [22:0] PROGRAM_ADDRESS_LITERAL;
  logic [23:0] FETCH_WORD;
  logic [31:0] seed, r;
  logic [24:0] fld;
  logic [38:0] rec;
  logic [38:0] eq[$];
  logic [8:0] fq[$];
  logic [8:0] fm;
  logic [9:0] ctl[9] = '{10'h201, 10'h203, 10'h205, 10'h306, 10'h307, 10'h237, 10'h23A, 10'h23B, 10'h23E};
  logic [7:0] dw[3] = '{8'h02, 8'h04, 8'h08};
  int err_total = 0, checked = 0, cyc = 0, i, j, k;

  dscid_decoder i_dut (.*);
  dscid_pmem i_mem (.clk(CLK_SYS), .gap(gap), .ready(FETCH_READY), .valid(FETCH_VALID), .word(FETCH_WORD),
    .cond(COND_TRUE), .skip(SKIP_TAKEN));

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [2:0] cls(input logic [7:0] op);
    if (op == `DSCID_OP_NOP) return `DSCID_CLS_NOP;
    if (op[7:6] == 2'h0) return `DSCID_CLS_CTRL;
    case (op[6:4])
      3'h3: return `DSCID_CLS_FILE;
      3'h4: return `DSCID_CLS_LIT;
      3'h5: return `DSCID_CLS_BIT;
      3'h6: return `DSCID_CLS_MAC;
      3'h7: return `DSCID_CLS_DSP;
      default: return `DSCID_CLS_WREG3;
    endcase
  endfunction
  task put(input logic c, input logic s, input logic [23:0] w);
    i_mem.push({c, s, w});
  endtask
  task note(input logic n, input logic [1:0] cy, input logic [7:0] op, input logic [24:0] f);
    eq.push_back(n ? {1'b1, 38'h0} : {1'b0, cy, op, cls(op), f});
  endtask
  task cmp_dec(input logic [38:0] e, input logic [38:0] g);
    checked++;
    if (e !== g) begin
      err_total++;
      $display("MISMATCH decode expected %h seen %h", e, g);
    end
  endtask
  task cmp_flag(input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (e !== g) begin
      err_total++;
      $display("MISMATCH flags expected %h seen %h", e, g);
    end
  endtask
  task drain(input string t);
    for (i = 0; i < 500 && (eq.size() != 0 || fq.size() != 0); i++) @(posedge CLK_SYS);
    if (eq.size() != 0 || fq.size() != 0) begin
      err_total++;
      $display("MISMATCH queue expected 0 seen %0d", eq.size() + fq.size());
    end
    $display("test %s done", t);
  endtask
  task stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge CLK_SYS) begin
    #1;
    gap = ^rnd();
  end
  always @(posedge CLK_SYS) begin
    #2;
    fld = 25'h0;
    case (DEC_CLASS)
      `DSCID_CLS_FILE: fld = {11'h0, DEST_IS_DEFAULT_WORKING_REG, FILE_ADDR};
      `DSCID_CLS_LIT: fld = {14'h0, LIT_RANGE_ERR, TEN_BIT_UNSIGNED_LITERAL};
      `DSCID_CLS_BIT: fld = {21'h0, BIT_SELECT_FIELD};
      `DSCID_CLS_WREG3: fld = {6'h0, DEC_SIZE, DEC_SHADOW, BASE_SOURCE_REG, SECOND_SOURCE_MODE, SECOND_SOURCE_REG,
        RESULT_DEST_MODE, RESULT_DEST_REG};
      `DSCID_CLS_MAC: fld = {4'h0, MUL_PAIR_ERR, ACC_SEL, MUL_REG_A, MUL_REG_B, X_PREFETCH, Y_PREFETCH,
        X_PREFETCH_DEST[1:0], Y_PREFETCH_DEST[1:0], ACC_WRITEBACK_POSTINC};
      `DSCID_CLS_DSP: fld = {17'h0, ACC_SEL, SHIFT_FROM_REG, SHIFT_LIT};
      `DSCID_CLS_CTRL: if (DEC_OPCODE inside {8'h02, 8'h04, 8'h08}) fld = {WORD2_ERR, PROG_ADDR_ERR, PROGRAM_ADDRESS_LITERAL};
      default: fld = 25'h0;
    endcase
    rec = DEC_NOP ? {1'b1, 38'h0} : {1'b0, DEC_CYCLES, DEC_OPCODE, DEC_CLASS, fld};
    if (DEC_VALID === 1'b1) cmp_dec(eq.size() != 0 ? eq.pop_front() : 39'hX, rec);
    if (fq.size() != 0) cmp_flag(fq.pop_front(), {ACC_B_SATURATE_FLAG, ACC_A_SATURATE_FLAG, ACC_B_OVERFLOW_FLAG,
      ACC_A_OVERFLOW_FLAG, ZERO_FLAG, OVERFLOW_FLAG, NEGATIVE_FLAG, DIGIT_CARRY_FLAG, CARRY_FLAG});
  end
  // Ceiling is well over ten times the expected run length
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      $display("timeout after %0d cycles", cyc);
      stop_test();
    end
  end

  initial begin
    seed = 32'h2945854B;
    {RST_N, EXE_Z_STICKY, EXE_FLAG_WE, EXE_FLAG_VAL, EXE_DSP_WE, EXE_DSP_VAL, fm} = 29'h0;
    gap = 1'b0;
    repeat (5) @(posedge CLK_SYS);
    #1 RST_N = 1'b1;
    repeat (4) begin
      r = rnd();
      put(1'b0, 1'b0, {8'hB0, r[15:0]});
      note(1'b0, `DSCID_CYC_1, 8'hB0, {11'h0, r[13:0]});
      put(1'b0, 1'b0, {8'h41, r[31:16]});
      note(1'b0, `DSCID_CYC_1, 8'h41, {14'h0, r[29:20] > 10'h0FF, r[29:20]});
      put(1'b0, 1'b0, {8'h50, r[23:8]});
      note(1'b0, `DSCID_CYC_1, 8'h50, {21'h0, r[23:20]});
    end
    drain("classes");
    repeat (3) begin
      r = rnd();
      put(1'b0, 1'b0, {8'h97, r[15:0]});
      note(1'b0, `DSCID_CYC_1, 8'h97, {6'h0, `DSCID_SIZE_WORD, 1'b1, r[15:0]});
      put(1'b0, 1'b0, {8'h9A, r[31:16]});
      note(1'b0, `DSCID_CYC_1, 8'h9A, {6'h0, `DSCID_SIZE_DBL, 1'b0, r[31:16]});
      put(1'b0, 1'b0, {7'h70, r[16], r[15:0]});
      note(1'b0, `DSCID_CYC_1, {7'h70, r[16]}, {4'h0, r[16] ? r[14:13] != r[12:11] : r[14:13] >= r[12:11],
        r[15], 4'h4 + {2'h0, r[14:13]}, 4'h4 + {2'h0, r[12:11]}, r[10:8], r[7:5], r[4:3], r[2:1], r[0]});
      put(1'b0, 1'b0, {8'hF0, r[15:0]});
      note(1'b0, `DSCID_CYC_1, 8'hF0, {17'h0, r[15], r[14], r[13:8]});
    end
    drain("operands");
    foreach (ctl[k]) begin
      r = rnd();
      put(1'b0, 1'b0, {ctl[k][7:0], r[15:0]});
      note(1'b0, ctl[k][9:8], ctl[k][7:0], 25'h0);
    end
    for (k = 0; k < 6; k++) begin
      r = rnd();
      put(r[0], 1'b0, {8'h30 + k[7:0], r[15:0]});
      note(1'b0, r[0] ? `DSCID_CYC_2 : `DSCID_CYC_1, 8'h30 + k[7:0], 25'h0);
    end
    drain("control");
    repeat (2) foreach (dw[k]) begin
      r = rnd();
      put(1'b0, 1'b0, {dw[k], r[15:0]});
      put(1'b0, 1'b0, {r[31] ? 8'h5A : 8'h00, 9'h0, r[22:16]});
      note(1'b0, `DSCID_CYC_2, dw[k], {r[31], r[0], r[22:0]});
    end
    put(1'b0, 1'b0, 24'h001234);
    note(1'b1, `DSCID_CYC_1, 8'h00, 25'h0);
    drain("two-word");
    put(1'b0, 1'b1, 24'h3C0000);
    note(1'b0, `DSCID_CYC_2, 8'h3C, 25'h0);
    put(1'b0, 1'b0, 24'hB01234);
    note(1'b1, `DSCID_CYC_1, 8'h00, 25'h0);
    put(1'b0, 1'b1, 24'h3C0000);
    note(1'b0, `DSCID_CYC_2, 8'h3C, 25'h0);
    put(1'b0, 1'b0, 24'h021000);
    put(1'b0, 1'b0, 24'h000001);
    repeat (2) note(1'b1, `DSCID_CYC_1, 8'h00, 25'h0);
    put(1'b0, 1'b0, 24'h3C0000);
    note(1'b0, `DSCID_CYC_1, 8'h3C, 25'h0);
    put(1'b0, 1'b0, 24'hB00042);
    note(1'b0, `DSCID_CYC_1, 8'hB0, 25'h0042);
    drain("skip");
    for (k = 0; k < 41; k++) begin
      @(posedge CLK_SYS);
      #1;
      if (k > 0) fq.push_back(fm);
      r = rnd();
      {EXE_DSP_VAL, EXE_DSP_WE, EXE_Z_STICKY, EXE_FLAG_VAL, EXE_FLAG_WE} = r[18:0];
      for (j = 0; j < 5; j++) if (r[j]) fm[j] = (j == 4 && r[10]) ? fm[4] & r[9] : r[5 + j];
      for (j = 0; j < 4; j++) if (r[11 + j]) fm[5 + j] = r[15 + j];
    end
    drain("flags");
    stop_test();
  end
endmodule

// ### test/dscid_pmem.sv
`timescale 1ns/10ps
module dscid_pmem (
  // Clock and pacing
  input logic clk,
  input logic gap,
  // Fetch port of the decoder
  input logic ready,
  output logic valid,
  output logic [23:0] word,
  output logic cond,
  output logic skip
);
  logic [25:0] q[$];
  logic g;
  initial {valid, cond, skip, word} = 27'h0000000;
  task push(input logic [25:0] e);
    q.push_back(e);
  endtask
  // A word stands until taken; idle lines flip every cycle so stale data never looks valid
  always @(posedge clk) begin
    g = gap;
    if (valid && ready) void'(q.pop_front());
    if (!valid || ready) begin
      #1;
      if (q.size() == 0 || g) {valid, cond, skip, word} = {1'b0, ~cond, ~skip, ~word};
      else {valid, cond, skip, word} = {1'b1, q[0]};
    end
  end
endmodule

// ### test/dscid_sva.sv
`timescale 1ns/10ps
`include "dscid_consts.vh"
module dscid_sva (
  // Clock and reset
  input logic CLK_SYS,
  input logic RST_N,
  // Fetch
  input logic FETCH_VALID,
  input logic [23:0] FETCH_WORD,
  input logic FETCH_READY,
  // Decode
  input logic DEC_VALID,
  input logic DEC_NOP,
  input logic NOP_SLOT,
  input logic [7:0] DEC_OPCODE,
  input logic [1:0] DEC_CYCLES,
  input logic [1:0] DEC_SIZE,
  input logic [2:0] DEC_CLASS,
  input logic [9:0] TEN_BIT_UNSIGNED_LITERAL,
  input logic LIT_RANGE_ERR,
  input logic [22:0] PROGRAM_ADDRESS_LITERAL,
  input logic PROG_ADDR_ERR,
  // Flags
  input logic [4:0] EXE_FLAG_WE,
  input logic [4:0] EXE_FLAG_VAL,
  input logic EXE_Z_STICKY,
  input logic ZERO_FLAG
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire real_dec = DEC_VALID && !DEC_NOP;
  wire two_word = DEC_OPCODE inside {`DSCID_OP_CALL, `DSCID_OP_GOTO, `DSCID_OP_DO};
  // Fetch is held off while the extra cycles run as no-operations
  sequence s_stall1;
    !FETCH_READY ##1 FETCH_READY && NOP_SLOT;
  endsequence
  sequence s_stall2;
    !FETCH_READY && !NOP_SLOT ##1 !FETCH_READY && NOP_SLOT ##1 FETCH_READY && NOP_SLOT;
  endsequence
  a_ret_stall: assert property (real_dec && DEC_CYCLES == `DSCID_CYC_3 |-> s_stall2)
    else $error("three-cycle stall walk wrong");
  a_two_stall: assert property (real_dec && DEC_CYCLES == `DSCID_CYC_2 && !two_word && DEC_OPCODE != `DSCID_OP_SKIP |-> s_stall1)
    else $error("two-cycle stall walk wrong");
  a_ret_cycles: assert property (real_dec && DEC_OPCODE inside {`DSCID_OP_RETURN, `DSCID_OP_RETINT} |-> DEC_CYCLES == `DSCID_CYC_3)
    else $error("return cycle count wrong");
  a_two_word_cyc: assert property (real_dec && two_word |-> DEC_CYCLES == `DSCID_CYC_2 && FETCH_READY)
    else $error("two-word cycle count wrong");
  a_opcode_field: assert property (real_dec && !two_word |-> DEC_OPCODE == $past(FETCH_WORD[23:16]))
    else $error("opcode not from top byte");
  a_addr_lsb: assert property (real_dec && DEC_OPCODE inside {`DSCID_OP_CALL, `DSCID_OP_GOTO} |-> PROG_ADDR_ERR == PROGRAM_ADDRESS_LITERAL[0])
    else $error("address lsb check wrong");
  a_lit_byte: assert property (real_dec && DEC_CLASS == `DSCID_CLS_LIT |-> LIT_RANGE_ERR == (DEC_SIZE == `DSCID_SIZE_BYTE && TEN_BIT_UNSIGNED_LITERAL > 10'h0FF))
    else $error("literal range flag wrong");
  a_zero_sticky: assert property (EXE_FLAG_WE[4] && EXE_Z_STICKY |=> ZERO_FLAG == ($past(ZERO_FLAG) & $past(EXE_FLAG_VAL[4])))
    else $error("sticky zero wrong");
endmodule
bind dscid_decoder dscid_sva i_sva (.*);
